// ==== hw/sense_debounce.sv ====
`timescale 1ns/1ps
module sense_debounce (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Timing enables
	input  wire logic       sample_tick,
	input  wire logic       period_tick,
	// Raw sense levels
	input  wire logic       hook_raw,
	input  wire logic       gk_raw,
	// Configuration
	input  wire logic [3:0] hook_period,
	input  wire logic [3:0] gk_interval,
	// Debounced levels
	output logic            hook_level,
	output logic            gk_level
);

	logic       hook_smp_ff;
	logic [3:0] hook_cnt_ff;
	logic [3:0] gk_tmr_ff;
	logic [2:0] gk_cnt_ff;

	wire logic hook_moved = sample_tick && (hook_raw != hook_smp_ff);
	wire logic hook_done  = (hook_cnt_ff == hook_period);
	wire logic gk_fire    = period_tick && ({1'b0, gk_tmr_ff} + 5'h01 >= {1'b0, gk_interval});
	wire logic gk_up      = gk_raw && (gk_cnt_ff != slic_sig_pkg::GK_TOP);
	wire logic gk_down    = !gk_raw && (gk_cnt_ff != slic_sig_pkg::GK_BOTTOM);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hook_smp_ff <= 1'b0;
			hook_cnt_ff <= 4'h0;
			hook_level  <= 1'b0;
		end else begin
			if (sample_tick)
				hook_smp_ff <= hook_raw;
			if (hook_moved)
				hook_cnt_ff <= 4'h0;
			else if (period_tick && !hook_done)
				hook_cnt_ff <= hook_cnt_ff + 4'h1;
			if (hook_done && !hook_moved)
				hook_level <= hook_smp_ff;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			gk_tmr_ff <= 4'h0;
			gk_cnt_ff <= slic_sig_pkg::GK_BOTTOM;
		end else begin
			if (gk_fire)
				gk_tmr_ff <= 4'h0;
			else if (period_tick)
				gk_tmr_ff <= gk_tmr_ff + 4'h1;
			if (gk_fire && gk_up)
				gk_cnt_ff <= gk_cnt_ff + 3'h1;
			else if (gk_fire && gk_down)
				gk_cnt_ff <= gk_cnt_ff - 3'h1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			gk_level <= 1'b0;
		else if (gk_cnt_ff == slic_sig_pkg::GK_TOP)
			gk_level <= 1'b1;
		else if (gk_cnt_ff == slic_sig_pkg::GK_BOTTOM)
			gk_level <= 1'b0;
	end

endmodule : sense_debounce

// ==== hw/slic_sig_pkg.sv ====
package slic_sig_pkg;

	// Serial control port states.
	typedef enum logic [2:0] {
		MPI_IDLE,
		MPI_CMD,
		MPI_WDATA,
		MPI_RLOAD,
		MPI_RDATA,
		MPI_DONE
	} mpi_state_t;

	localparam int NUM_CH    = 4;
	localparam int NUM_SRC   = 5;
	localparam int NUM_BIDIR = 3;
	localparam int NUM_OUT   = 5;

	// Command byte layout.
	localparam int CMD_READ_BIT   = 7;
	localparam int CMD_GLOBAL_BIT = 6;
	localparam int CMD_CH_MSB     = 5;
	localparam int CMD_CH_LSB     = 4;
	localparam int CMD_REG_MSB    = 3;

	// Global register indices.
	localparam logic [3:0] GREG_IRQ_CLEAR   = 4'h2;
	localparam logic [3:0] RING_TRIP_CONFIG = 4'h8;
	localparam logic [3:0] SENSE_STATUS     = 4'h9;
	localparam logic [3:0] BIDIR1_CTRL_DATA = 4'hA;
	localparam logic [3:0] BIDIR2_CTRL_DATA = 4'hB;
	localparam logic [3:0] BIDIR3_CTRL_DATA = 4'hC;

	// Local register indices.
	localparam logic [3:0] CH_IRQ_ENABLE    = 4'h2;
	localparam logic [3:0] CH_DEBOUNCE_CFG  = 4'h3;
	localparam logic [3:0] CH_SIGNALING_IO  = 4'h4;

	// Reset values.
	localparam logic [7:0] RING_TRIP_RST = 8'h00;
	localparam logic [3:0] BIDIR_DIR_RST = 4'h0;
	localparam logic [3:0] BIDIR_DAT_RST = 4'h0;
	localparam logic [4:0] IRQ_EN_RST    = 5'h00;
	localparam logic [7:0] DEB_CFG_RST   = 8'h00;
	localparam logic [1:0] CTRL_OUT_RST  = 2'h0;

	// Ring trip configuration fields.
	localparam int RT_ENABLE      = 0;
	localparam int RT_IN_SEL      = 1;
	localparam int RT_OUT_SEL_LSB = 2;
	localparam int RT_OUT_SEL_MSB = 4;
	localparam int RT_IN_POL      = 5;
	localparam int RT_OUT_POL     = 6;

	// Bidirectional register: direction in the high nibble, data in the low.
	localparam int BIDIR_DIR_LSB  = 4;
	localparam int BIDIR_DIR_MSB  = 7;

	// Debounce configuration fields.
	localparam int DEB_HOOK_LSB   = 4;
	localparam int DEB_HOOK_MSB   = 7;
	localparam int DEB_GK_LSB     = 0;
	localparam int DEB_GK_MSB     = 3;

	// Signaling I/O register bits.
	localparam int IO_CTRL1       = 5;
	localparam int IO_CTRL2       = 6;

	// Ring trip output select codes.
	localparam logic [2:0] OUT_CTRL1  = 3'h0;
	localparam logic [2:0] OUT_BIDIR3 = 3'h4;

	// Debounce timing derived from the frame sync.
	localparam int FRAME_PERIOD_US   = 125;
	localparam int HOOK_SAMPLE_US    = 250;
	localparam int DEBOUNCE_TICK_US  = 2000;
	localparam int FRAMES_PER_SAMPLE = HOOK_SAMPLE_US / FRAME_PERIOD_US;
	localparam int SAMPLES_PER_TICK  = DEBOUNCE_TICK_US / HOOK_SAMPLE_US;
	localparam logic [2:0] FS_DIV_LAST  = 3'(FRAMES_PER_SAMPLE - 1);
	localparam logic [3:0] SMP_DIV_LAST = 4'(SAMPLES_PER_TICK - 1);

	// Ground key counter bounds.
	localparam logic [2:0] GK_TOP    = 3'h6;
	localparam logic [2:0] GK_BOTTOM = 3'h0;

endpackage : slic_sig_pkg

// ==== hw/slic_signaling_ring_trip.sv ====
`timescale 1ns/1ps
module slic_signaling_ring_trip (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Serial control port
	input  wire logic       ctrl_clk,
	input  wire logic       ctrl_sel_n,
	input  wire logic       ctrl_din,
	output logic            ctrl_dout,
	output logic            ctrl_dout_oe,
	// Frame timing
	input  wire logic       frame_sync,
	// Sense inputs, one bit per channel
	input  wire logic [3:0] hook_sense_in,
	input  wire logic [3:0] ground_key_in,
	// Bidirectional lines
	input  wire logic [3:0] bidir_line_1_in,
	output wire logic [3:0] bidir_line_1_out,
	output wire logic [3:0] bidir_line_1_oe,
	input  wire logic [3:0] bidir_line_2_in,
	output wire logic [3:0] bidir_line_2_out,
	output wire logic [3:0] bidir_line_2_oe,
	input  wire logic [3:0] bidir_line_3_in,
	output wire logic [3:0] bidir_line_3_out,
	output wire logic [3:0] bidir_line_3_oe,
	// Control outputs
	output wire logic [3:0] line_ctrl_out_1,
	output wire logic [3:0] line_ctrl_out_2,
	// Pending signaling event
	output logic            irq_pending
);

	function automatic logic reg_hit(input logic glob, input logic [3:0] idx,
			input logic want_glob, input logic [3:0] want);
		return (glob == want_glob) && (idx == want);
	endfunction : reg_hit

	function automatic logic [4:0] out_onehot(input logic [2:0] sel);
		return (sel <= slic_sig_pkg::OUT_BIDIR3) ? (5'h01 << sel) : 5'h00;
	endfunction : out_onehot

	slic_sig_pkg::mpi_state_t state_ff;
	slic_sig_pkg::mpi_state_t nxt_state;

	logic       cclk_prev_ff;
	logic [2:0] bit_cnt_ff;
	logic [7:0] shift_in_ff;
	logic [7:0] shift_out_ff;
	logic [7:0] cmd_ff;
	logic [7:0] wr_data_ff;
	logic       wr_stb_ff;
	logic [7:0] rd_data;

	logic       fs_prev_ff;
	logic [2:0] fs_cnt_ff;
	logic [3:0] smp_cnt_ff;
	logic       sample_tick_ff;
	logic       period_tick_ff;

	logic [7:0] ring_cfg_ff;
	logic [3:0] bidir_dir_ff  [slic_sig_pkg::NUM_BIDIR];
	logic [3:0] bidir_data_ff [slic_sig_pkg::NUM_BIDIR];
	logic [3:0] bidir_lvl     [slic_sig_pkg::NUM_BIDIR];
	logic [3:0] sb_in         [slic_sig_pkg::NUM_BIDIR];
	logic [2:0] wr_bidir;
	logic [2:0] rd_bidir;

	logic [4:0] irq_en_ff   [slic_sig_pkg::NUM_CH];
	logic [7:0] deb_cfg_ff  [slic_sig_pkg::NUM_CH];
	logic [1:0] ctrl_ff     [slic_sig_pkg::NUM_CH];
	logic [4:0] pend_ff     [slic_sig_pkg::NUM_CH];
	logic [4:0] src_prev_ff [slic_sig_pkg::NUM_CH];
	logic [4:0] out_pin_ff  [slic_sig_pkg::NUM_CH];
	logic       trip_ff     [slic_sig_pkg::NUM_CH];
	logic [7:0] io_read     [slic_sig_pkg::NUM_CH];
	logic [3:0] hook_db;
	logic [3:0] gk_db;
	logic [3:0] pend_any;

	// Serial port decode; the pins are sampled as synchronous levels.
	wire logic       cclk_rise = ctrl_clk & ~cclk_prev_ff;
	wire logic       cclk_fall = ~ctrl_clk & cclk_prev_ff;
	wire logic       byte_done = cclk_rise && (bit_cnt_ff == 3'h7);
	wire logic [7:0] byte_in   = {shift_in_ff[6:0], ctrl_din};
	wire logic       acc_glob  = cmd_ff[slic_sig_pkg::CMD_GLOBAL_BIT];
	wire logic [3:0] acc_idx   = cmd_ff[slic_sig_pkg::CMD_REG_MSB:0];
	wire logic [1:0] acc_ch    = cmd_ff[slic_sig_pkg::CMD_CH_MSB:slic_sig_pkg::CMD_CH_LSB];
	// The read strobe coincides with the capture so an event landing now survives the clear.
	wire logic       rd_stb    = (state_ff == slic_sig_pkg::MPI_RLOAD);

	wire logic wr_ring  = wr_stb_ff && reg_hit(acc_glob, acc_idx, 1'b1,
		slic_sig_pkg::RING_TRIP_CONFIG);
	wire logic wr_clear = wr_stb_ff && reg_hit(acc_glob, acc_idx, 1'b1,
		slic_sig_pkg::GREG_IRQ_CLEAR);
	wire logic rd_sense = rd_stb && reg_hit(acc_glob, acc_idx, 1'b1,
		slic_sig_pkg::SENSE_STATUS);

	wire logic       trip_en  = ring_cfg_ff[slic_sig_pkg::RT_ENABLE];
	wire logic [2:0] trip_sel = ring_cfg_ff[slic_sig_pkg::RT_OUT_SEL_MSB:slic_sig_pkg::RT_OUT_SEL_LSB];
	wire logic [4:0] trip_hot = out_onehot(trip_sel);

	assign sb_in[0] = bidir_line_1_in;
	assign sb_in[1] = bidir_line_2_in;
	assign sb_in[2] = bidir_line_3_in;

	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			slic_sig_pkg::MPI_IDLE:  nxt_state = slic_sig_pkg::MPI_CMD;
			slic_sig_pkg::MPI_CMD: begin
				if (byte_done)
					nxt_state = byte_in[slic_sig_pkg::CMD_READ_BIT] ?
						slic_sig_pkg::MPI_RLOAD : slic_sig_pkg::MPI_WDATA;
			end
			slic_sig_pkg::MPI_WDATA: begin
				if (byte_done)
					nxt_state = slic_sig_pkg::MPI_DONE;
			end
			slic_sig_pkg::MPI_RLOAD: nxt_state = slic_sig_pkg::MPI_RDATA;
			slic_sig_pkg::MPI_RDATA: begin
				if (byte_done)
					nxt_state = slic_sig_pkg::MPI_RLOAD;
			end
			slic_sig_pkg::MPI_DONE:  nxt_state = slic_sig_pkg::MPI_DONE;
			default:                 nxt_state = slic_sig_pkg::MPI_IDLE;
		endcase
		if (ctrl_sel_n)
			nxt_state = slic_sig_pkg::MPI_IDLE;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff     <= slic_sig_pkg::MPI_IDLE;
			cclk_prev_ff <= 1'b0;
			bit_cnt_ff   <= 3'h0;
			shift_in_ff  <= 8'h00;
		end else begin
			state_ff     <= nxt_state;
			cclk_prev_ff <= ctrl_clk;
			if (ctrl_sel_n)
				bit_cnt_ff <= 3'h0;
			else if (cclk_rise)
				bit_cnt_ff <= bit_cnt_ff + 3'h1;
			if (cclk_rise)
				shift_in_ff <= byte_in;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cmd_ff     <= 8'h00;
			wr_data_ff <= 8'h00;
			wr_stb_ff  <= 1'b0;
		end else begin
			if (state_ff == slic_sig_pkg::MPI_CMD && byte_done && !ctrl_sel_n)
				cmd_ff <= byte_in;
			wr_stb_ff <= (state_ff == slic_sig_pkg::MPI_WDATA) && byte_done && !ctrl_sel_n;
			if (state_ff == slic_sig_pkg::MPI_WDATA && byte_done)
				wr_data_ff <= byte_in;
		end
	end

	// Read data leaves MSB first, changing on falling edges of the port clock.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			shift_out_ff <= 8'h00;
			ctrl_dout    <= 1'b0;
			ctrl_dout_oe <= 1'b0;
		end else begin
			ctrl_dout_oe <= (nxt_state == slic_sig_pkg::MPI_RLOAD) ||
				(nxt_state == slic_sig_pkg::MPI_RDATA);
			if (rd_stb)
				shift_out_ff <= rd_data;
			else if (cclk_fall && state_ff == slic_sig_pkg::MPI_RDATA) begin
				ctrl_dout    <= shift_out_ff[7];
				shift_out_ff <= {shift_out_ff[6:0], 1'b0};
			end
		end
	end

	always_comb begin
		rd_data = 8'h00;
		if (acc_glob) begin
			case (acc_idx)
				slic_sig_pkg::RING_TRIP_CONFIG: rd_data = ring_cfg_ff;
				slic_sig_pkg::SENSE_STATUS:     rd_data = {gk_db, hook_db};
				slic_sig_pkg::BIDIR1_CTRL_DATA: rd_data = {bidir_dir_ff[0], bidir_lvl[0]};
				slic_sig_pkg::BIDIR2_CTRL_DATA: rd_data = {bidir_dir_ff[1], bidir_lvl[1]};
				slic_sig_pkg::BIDIR3_CTRL_DATA: rd_data = {bidir_dir_ff[2], bidir_lvl[2]};
				default:                        rd_data = 8'h00;
			endcase
		end else begin
			case (acc_idx)
				slic_sig_pkg::CH_IRQ_ENABLE:   rd_data = {3'h0, irq_en_ff[acc_ch]};
				slic_sig_pkg::CH_DEBOUNCE_CFG: rd_data = deb_cfg_ff[acc_ch];
				slic_sig_pkg::CH_SIGNALING_IO: rd_data = io_read[acc_ch];
				default:                       rd_data = 8'h00;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			fs_prev_ff     <= 1'b0;
			fs_cnt_ff      <= 3'h0;
			smp_cnt_ff     <= 4'h0;
			sample_tick_ff <= 1'b0;
			period_tick_ff <= 1'b0;
		end else begin
			fs_prev_ff     <= frame_sync;
			sample_tick_ff <= 1'b0;
			period_tick_ff <= 1'b0;
			if (frame_sync && !fs_prev_ff) begin
				fs_cnt_ff <= (fs_cnt_ff == slic_sig_pkg::FS_DIV_LAST) ? 3'h0 : fs_cnt_ff + 3'h1;
				if (fs_cnt_ff == slic_sig_pkg::FS_DIV_LAST) begin
					sample_tick_ff <= 1'b1;
					smp_cnt_ff     <= (smp_cnt_ff == slic_sig_pkg::SMP_DIV_LAST) ?
						4'h0 : smp_cnt_ff + 4'h1;
					period_tick_ff <= (smp_cnt_ff == slic_sig_pkg::SMP_DIV_LAST);
				end
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			ring_cfg_ff <= slic_sig_pkg::RING_TRIP_RST;
		else if (wr_ring)
			ring_cfg_ff <= wr_data_ff;
	end

	genvar k;
	generate
		for (k = 0; k < slic_sig_pkg::NUM_BIDIR; k++) begin : g_bidir
			assign wr_bidir[k] = wr_stb_ff && reg_hit(acc_glob, acc_idx, 1'b1,
				4'(slic_sig_pkg::BIDIR1_CTRL_DATA + k));
			assign rd_bidir[k] = rd_stb && reg_hit(acc_glob, acc_idx, 1'b1,
				4'(slic_sig_pkg::BIDIR1_CTRL_DATA + k));
			assign bidir_lvl[k] = (bidir_dir_ff[k] & bidir_data_ff[k]) |
				(~bidir_dir_ff[k] & sb_in[k]);
			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					bidir_dir_ff[k]  <= slic_sig_pkg::BIDIR_DIR_RST;
					bidir_data_ff[k] <= slic_sig_pkg::BIDIR_DAT_RST;
				end else if (wr_bidir[k]) begin
					bidir_dir_ff[k]  <= wr_data_ff[slic_sig_pkg::BIDIR_DIR_MSB:
						slic_sig_pkg::BIDIR_DIR_LSB];
					bidir_data_ff[k] <= wr_data_ff[3:0];
				end
			end
		end
	endgenerate

	assign bidir_line_1_oe = bidir_dir_ff[0];
	assign bidir_line_2_oe = bidir_dir_ff[1];
	assign bidir_line_3_oe = bidir_dir_ff[2];

	genvar c;
	generate
		for (c = 0; c < slic_sig_pkg::NUM_CH; c++) begin : g_ch
			wire logic ch_hit = (acc_ch == 2'(c));
			wire logic wr_ien = wr_stb_ff && ch_hit && reg_hit(acc_glob, acc_idx, 1'b0,
				slic_sig_pkg::CH_IRQ_ENABLE);
			wire logic wr_deb = wr_stb_ff && ch_hit && reg_hit(acc_glob, acc_idx, 1'b0,
				slic_sig_pkg::CH_DEBOUNCE_CFG);
			wire logic wr_io  = wr_stb_ff && ch_hit && reg_hit(acc_glob, acc_idx, 1'b0,
				slic_sig_pkg::CH_SIGNALING_IO);
			wire logic rd_io  = rd_stb && ch_hit && reg_hit(acc_glob, acc_idx, 1'b0,
				slic_sig_pkg::CH_SIGNALING_IO);
			// Bidir data only from global registers.
			wire logic [4:0] drive_val = {bidir_data_ff[2][c], bidir_data_ff[1][c],
				bidir_data_ff[0][c], ctrl_ff[c]};
			wire logic [4:0] out_mask  = {bidir_dir_ff[2][c], bidir_dir_ff[1][c],
				bidir_dir_ff[0][c], 2'b11};
			wire logic [4:0] in_mask   = {~bidir_dir_ff[2][c], ~bidir_dir_ff[1][c],
				~bidir_dir_ff[0][c], 2'b11};
			wire logic [4:0] hot       = trip_hot & out_mask;
			wire logic trip_in   = ring_cfg_ff[slic_sig_pkg::RT_IN_SEL] ? gk_db[c] : hook_db[c];
			wire logic off_hook  = (trip_in == ring_cfg_ff[slic_sig_pkg::RT_IN_POL]);
			wire logic ringing   = |(hot & (ring_cfg_ff[slic_sig_pkg::RT_OUT_POL] ?
				drive_val : ~drive_val));
			wire logic sel_wr    = |(hot & {wr_bidir, wr_io, wr_io});
			wire logic nxt_trip  = trip_en && ((off_hook && ringing) || (trip_ff[c] && !sel_wr));
			wire logic [4:0] src = {sb_in[2][c], sb_in[1][c], sb_in[0][c], gk_db[c], hook_db[c]};
			wire logic [4:0] change = (src ^ src_prev_ff[c]) & in_mask & irq_en_ff[c];
			wire logic [4:0] clr = {5{wr_clear | rd_io}} | {rd_bidir, rd_sense, rd_sense};
			wire logic [4:0] nxt_pend = change | (pend_ff[c] & ~clr);

			sense_debounce u_debounce (
				.sys_clk     (sys_clk),
				.rst         (rst),
				.sample_tick (sample_tick_ff),
				.period_tick (period_tick_ff),
				.hook_raw    (hook_sense_in[c]),
				.gk_raw      (ground_key_in[c]),
				.hook_period (deb_cfg_ff[c][slic_sig_pkg::DEB_HOOK_MSB:slic_sig_pkg::DEB_HOOK_LSB]),
				.gk_interval (deb_cfg_ff[c][slic_sig_pkg::DEB_GK_MSB:slic_sig_pkg::DEB_GK_LSB]),
				.hook_level  (hook_db[c]),
				.gk_level    (gk_db[c])
			);

			assign io_read[c]  = {|pend_ff[c], ctrl_ff[c], bidir_lvl[2][c], bidir_lvl[1][c],
				bidir_lvl[0][c], ground_key_in[c], hook_sense_in[c]};
			assign pend_any[c] = |pend_ff[c];

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					irq_en_ff[c]  <= slic_sig_pkg::IRQ_EN_RST;
					deb_cfg_ff[c] <= slic_sig_pkg::DEB_CFG_RST;
					ctrl_ff[c]    <= slic_sig_pkg::CTRL_OUT_RST;
				end else begin
					if (wr_ien)
						irq_en_ff[c] <= wr_data_ff[4:0];
					if (wr_deb)
						deb_cfg_ff[c] <= wr_data_ff;
					if (wr_io)
						ctrl_ff[c] <= wr_data_ff[slic_sig_pkg::IO_CTRL2:slic_sig_pkg::IO_CTRL1];
				end
			end

			always_ff @(posedge sys_clk or posedge rst) begin
				if (rst) begin
					trip_ff[c]     <= 1'b0;
					pend_ff[c]     <= 5'h00;
					src_prev_ff[c] <= 5'h00;
					out_pin_ff[c]  <= 5'h00;
				end else begin
					trip_ff[c]     <= nxt_trip;
					pend_ff[c]     <= nxt_pend;
					src_prev_ff[c] <= src;
					out_pin_ff[c]  <= drive_val ^ (nxt_trip ? hot : 5'h00);
				end
			end

			assign line_ctrl_out_1[c]  = out_pin_ff[c][0];
			assign line_ctrl_out_2[c]  = out_pin_ff[c][1];
			assign bidir_line_1_out[c] = out_pin_ff[c][2];
			assign bidir_line_2_out[c] = out_pin_ff[c][3];
			assign bidir_line_3_out[c] = out_pin_ff[c][4];
		end
	endgenerate

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			irq_pending <= 1'b0;
		else
			irq_pending <= |pend_any;
	end

endmodule : slic_signaling_ring_trip

// ==== test/slic_line_model.sv ====
`timescale 1ns/1ps
module slic_line_model (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Levels the line circuit wants
	input  wire logic [3:0]  hook_lvl,
	input  wire logic [3:0]  gk_lvl,
	input  wire logic [11:0] pin_lvl,
	// Device side of the shared lines
	input  wire logic [11:0] dev_out,
	input  wire logic [11:0] dev_oe,
	// Lines as seen at the pins
	output logic             frame_sync,
	output logic [3:0]       hook_sense_in,
	output logic [3:0]       ground_key_in,
	output logic [11:0]      line_lvl
);
	logic [2:0] fs_cnt_ff;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			fs_cnt_ff <= 3'h0;
		else
			fs_cnt_ff <= fs_cnt_ff + 3'h1;
	end
	// A fast sync keeps the debounce timing short in simulation.
	assign frame_sync = fs_cnt_ff == 3'h7;
	assign hook_sense_in = hook_lvl;
	assign ground_key_in = gk_lvl;
	assign line_lvl = (dev_out & dev_oe) | (pin_lvl & ~dev_oe);
endmodule : slic_line_model

// ==== test/slic_sig_props.sv ====
`timescale 1ns/1ps
module slic_sig_props (
	// Clock and reset
	input wire logic       sys_clk,
	input wire logic       rst,
	// Serial control port
	input wire logic       ctrl_clk,
	input wire logic       ctrl_sel_n,
	input wire logic       ctrl_din,
	input wire logic       ctrl_dout,
	input wire logic       ctrl_dout_oe,
	// Pins and event
	input wire logic [3:0] bidir_line_1_out,
	input wire logic [3:0] bidir_line_1_oe,
	input wire logic [3:0] bidir_line_2_oe,
	input wire logic [3:0] bidir_line_3_oe,
	input wire logic       irq_pending
);
	logic [5:0] rise_ff;
	logic [7:0] cmd_ff;
	logic       clk_q_ff;
	logic       sel_q_ff;

	// The count is only cleared by the next select, so late register updates still see it.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rise_ff  <= 6'h00;
			cmd_ff   <= 8'h00;
			clk_q_ff <= 1'b0;
			sel_q_ff <= 1'b1;
		end else begin
			clk_q_ff <= ctrl_clk;
			sel_q_ff <= ctrl_sel_n;
			if (sel_q_ff && !ctrl_sel_n)
				rise_ff <= 6'h00;
			else if (ctrl_clk && !clk_q_ff && !ctrl_sel_n && rise_ff != 6'h3F) begin
				rise_ff <= rise_ff + 6'h01;
				if (rise_ff < 6'h08)
					cmd_ff <= {cmd_ff[6:0], ctrl_din};
			end
		end
	end

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	sequence s_desel;
		$rose(ctrl_sel_n) ##3 1'b1;
	endsequence

	a_read_after_cmd: assert property ($rose(ctrl_dout_oe) |-> rise_ff == 6'h08 && cmd_ff[7])
		else $error("read output enabled off the command boundary");
	a_oe_on_deselect: assert property (s_desel |-> !ctrl_dout_oe)
		else $error("read output still enabled after deselect");
	a_oe_drop_cause: assert property ($fell(ctrl_dout_oe) |-> $past(ctrl_sel_n))
		else $error("read output dropped while selected");
	a_dout_on_fall: assert property (ctrl_dout_oe && $past(ctrl_dout_oe) && $changed(ctrl_dout)
		|-> !ctrl_clk)
		else $error("read data changed while serial clock high");
	a_dir_by_write: assert property ($changed({bidir_line_1_oe, bidir_line_2_oe, bidir_line_3_oe})
		|-> rise_ff == 6'h10 && cmd_ff[7:6] == 2'b01)
		else $error("direction changed without a global write");
	a_out_only_driven: assert property ($changed(bidir_line_1_out) && rise_ff != 6'h10
		|-> ((bidir_line_1_out ^ $past(bidir_line_1_out)) & ~bidir_line_1_oe) == 4'h0)
		else $error("undriven line level moved without a write");
	a_clear_by_access: assert property ($fell(irq_pending)
		|-> rise_ff != 6'h00 && rise_ff[2:0] == 3'h0)
		else $error("pending event dropped outside a register access");
	a_write_no_oe: assert property (rise_ff == 6'h10 && !cmd_ff[7] |-> !ctrl_dout_oe)
		else $error("read output enabled during a write");
endmodule : slic_sig_props

bind slic_signaling_ring_trip slic_sig_props u_props (
	.sys_clk(sys_clk), .rst(rst), .ctrl_clk(ctrl_clk), .ctrl_sel_n(ctrl_sel_n),
	.ctrl_din(ctrl_din), .ctrl_dout(ctrl_dout), .ctrl_dout_oe(ctrl_dout_oe),
	.bidir_line_1_out(bidir_line_1_out), .bidir_line_1_oe(bidir_line_1_oe),
	.bidir_line_2_oe(bidir_line_2_oe), .bidir_line_3_oe(bidir_line_3_oe),
	.irq_pending(irq_pending)
);

// ==== test/slic_signaling_ring_trip_tb.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	check_count++; \
	if ((g) !== (e)) begin \
		bad_count++; \
		$display("mismatch %s expected %h seen %h", n, e, g); \
	end \
end
module slic_signaling_ring_trip_tb;
	localparam int PH = 6;
	logic        sys_clk = 1'b0;
	logic        rst = 1'b1;
	logic        ctrl_clk = 1'b0;
	logic        ctrl_sel_n = 1'b1;
	logic        ctrl_din = 1'b0;
	logic [3:0]  hook_lvl = 4'h7;
	logic [3:0]  gk_lvl = 4'h9;
	logic [11:0] pin_lvl = 12'h00C;
	logic [7:0]  r;
	int          bad_count = 0;
	int          check_count = 0;
	wire         ctrl_dout, ctrl_dout_oe, frame_sync, irq_pending;
	wire [3:0]   hook_sense_in, ground_key_in, ctl1, ctl2;
	wire [11:0]  dev_out, dev_oe, line_lvl;

	always #2.5 sys_clk = ~sys_clk;

	slic_line_model partner (
		.sys_clk(sys_clk), .rst(rst), .hook_lvl(hook_lvl), .gk_lvl(gk_lvl),
		.pin_lvl(pin_lvl), .dev_out(dev_out), .dev_oe(dev_oe), .frame_sync(frame_sync),
		.hook_sense_in(hook_sense_in), .ground_key_in(ground_key_in), .line_lvl(line_lvl)
	);
	slic_signaling_ring_trip dut (
		.sys_clk(sys_clk), .rst(rst), .ctrl_clk(ctrl_clk), .ctrl_sel_n(ctrl_sel_n),
		.ctrl_din(ctrl_din), .ctrl_dout(ctrl_dout), .ctrl_dout_oe(ctrl_dout_oe),
		.frame_sync(frame_sync), .hook_sense_in(hook_sense_in), .ground_key_in(ground_key_in),
		.bidir_line_1_in(line_lvl[3:0]), .bidir_line_1_out(dev_out[3:0]),
		.bidir_line_1_oe(dev_oe[3:0]), .bidir_line_2_in(line_lvl[7:4]),
		.bidir_line_2_out(dev_out[7:4]), .bidir_line_2_oe(dev_oe[7:4]),
		.bidir_line_3_in(line_lvl[11:8]), .bidir_line_3_out(dev_out[11:8]),
		.bidir_line_3_oe(dev_oe[11:8]), .line_ctrl_out_1(ctl1), .line_ctrl_out_2(ctl2),
		.irq_pending(irq_pending)
	);

	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : tick

	// Read data is taken just before each rise, where it has settled since the fall.
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] sh;
		sh = {cmd, wd};
		ctrl_sel_n = 1'b0;
		for (int i = 0; i < 16; i++) begin
			ctrl_din = sh[15 - i];
			tick(PH);
			rd = {rd[6:0], ctrl_dout};
			ctrl_clk = 1'b1;
			tick(PH);
			ctrl_clk = 1'b0;
		end
		tick(PH);
		ctrl_sel_n = 1'b1;
		tick(3);
	endtask : xfer

	task automatic wr(input logic g, input logic [1:0] ch, input logic [3:0] ix, input logic [7:0] d);
		logic [7:0] junk;
		xfer({1'b0, g, ch, ix}, d, junk);
	endtask : wr

	task automatic rd(input logic g, input logic [1:0] ch, input logic [3:0] ix, output logic [7:0] d);
		xfer({1'b1, g, ch, ix}, 8'h00, d);
	endtask : rd

	task automatic summarize();
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize

	initial begin
		tick(10);
		rst = 1'b0;
		tick(2);
		rd(1'b1, 2'h0, slic_sig_pkg::RING_TRIP_CONFIG, r);
		`CHK("ring_trip_config", 8'h00, r)
		rd(1'b0, 2'h1, slic_sig_pkg::CH_IRQ_ENABLE, r);
		`CHK("channel_irq_enable", 8'h00, r)
		wr(1'b1, 2'h0, slic_sig_pkg::BIDIR1_CTRL_DATA, 8'h35);
		`CHK("line1 oe", 4'h3, dev_oe[3:0])
		`CHK("line1 out", 2'h1, dev_out[1:0])
		rd(1'b1, 2'h0, slic_sig_pkg::BIDIR1_CTRL_DATA, r);
		`CHK("bidir_pin1_ctrl_data", 8'h3D, r)
		wr(1'b0, 2'h1, slic_sig_pkg::CH_SIGNALING_IO, 8'h60);
		rd(1'b0, 2'h1, slic_sig_pkg::CH_SIGNALING_IO, r);
		`CHK("ctrl pins", 4'h3, {ctl2[1:0], ctl1[1:0]} & 4'hA ^ 4'h8 ^ 4'h1)
		`CHK("signaling_io ctrl", 2'h3, r[6:5])
		`CHK("signaling_io levels", 5'h01, r[4:0])
		tick(400);
		rd(1'b1, 2'h0, slic_sig_pkg::SENSE_STATUS, r);
		`CHK("debounced_sense_status", 8'h97, r)
		wr(1'b0, 2'h0, slic_sig_pkg::CH_IRQ_ENABLE, 8'h01);
		wr(1'b1, 2'h0, slic_sig_pkg::GREG_IRQ_CLEAR, 8'h00);
		gk_lvl = 4'h8;
		hook_lvl = 4'h5;
		tick(400);
		`CHK("irq masked", 1'b0, irq_pending)
		rd(1'b1, 2'h0, slic_sig_pkg::SENSE_STATUS, r);
		`CHK("status hold", 8'h95, r)
		gk_lvl = 4'h9;
		hook_lvl = 4'h4;
		tick(400);
		`CHK("irq hook", 1'b1, irq_pending)
		rd(1'b1, 2'h0, slic_sig_pkg::SENSE_STATUS, r);
		`CHK("irq status read", 1'b0, irq_pending)
		wr(1'b0, 2'h2, slic_sig_pkg::CH_IRQ_ENABLE, 8'h04);
		pin_lvl = 12'h008;
		tick(4);
		`CHK("irq raw line", 1'b1, irq_pending)
		rd(1'b0, 2'h2, slic_sig_pkg::CH_SIGNALING_IO, r);
		`CHK("irq local read", 1'b0, irq_pending)
		pin_lvl = 12'h00C;
		tick(4);
		rd(1'b1, 2'h0, slic_sig_pkg::BIDIR1_CTRL_DATA, r);
		`CHK("irq line read", 1'b0, irq_pending)
		pin_lvl = 12'h008;
		tick(4);
		wr(1'b1, 2'h0, slic_sig_pkg::GREG_IRQ_CLEAR, 8'h00);
		`CHK("irq clear write", 1'b0, irq_pending)
		hook_lvl = 4'hF;
		tick(400);
		wr(1'b0, 2'h0, slic_sig_pkg::CH_SIGNALING_IO, 8'h20);
		wr(1'b1, 2'h0, slic_sig_pkg::RING_TRIP_CONFIG, 8'h41);
		`CHK("ringing", 4'h3, ctl1)
		hook_lvl = 4'hE;
		tick(400);
		`CHK("tripped", 4'h2, ctl1)
		hook_lvl = 4'hF;
		tick(400);
		`CHK("trip held", 4'h2, ctl1)
		wr(1'b0, 2'h0, slic_sig_pkg::CH_SIGNALING_IO, 8'h20);
		`CHK("trip rewritten", 4'h3, ctl1)
		wr(1'b1, 2'h0, slic_sig_pkg::RING_TRIP_CONFIG, 8'h40);
		hook_lvl = 4'hE;
		tick(400);
		`CHK("trip disabled", 4'h3, ctl1)
		wr(1'b1, 2'h0, slic_sig_pkg::RING_TRIP_CONFIG, 8'h29);
		tick(4);
		`CHK("trip line high", 2'h3, dev_out[1:0])
		wr(1'b1, 2'h0, slic_sig_pkg::RING_TRIP_CONFIG, 8'h47);
		tick(4);
		`CHK("trip on ctrl2 by ground key", 4'h0, ctl2)
		wr(1'b1, 2'h0, slic_sig_pkg::BIDIR3_CTRL_DATA, 8'hFA);
		`CHK("line3 oe and out", 8'hFA, {dev_oe[11:8], dev_out[11:8]})
		summarize();
	end

	initial begin
		tick(40000);
		bad_count++;
		summarize();
	end
endmodule : slic_signaling_ring_trip_tb
